// *** hw/swrx_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module swrx_top
  import swrx_pkg::*;
#(
  parameter int TIMEOUT_TICKS_P = TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // single-wire link
  input  wire logic        swif_din,
  output logic             ack_pulldown_n,
  output logic             ack_pulldown_oe,
  // loop and fault pins
  input  wire logic        loop_fail,
  input  wire logic        alarm_band_select,
  output logic             fault_flag_n,
  output logic             fault_flag_oe,
  output logic [15:0]      conversion_out,
  output logic             irq
);

  // pin synchronisers: {loop, band, din}
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       din_d_reg;
  logic       din;
  logic       band;
  logic       loop_in;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      din_d_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= {loop_fail, alarm_band_select, swif_din};
      sync2_reg <= sync1_reg;
      din_d_reg <= sync2_reg[0];
    end
  end

  assign din     = sync2_reg[0];
  assign band    = sync2_reg[1];
  assign loop_in = sync2_reg[2];

  // internal timer tick
  logic [7:0] tick_cnt_reg;
  logic       tick;

  assign tick = (tick_cnt_reg == 8'(TICK_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end

  // high time and period of the running symbol, saturating
  logic [15:0] hi_cnt_reg;
  logic [15:0] per_cnt_reg;
  logic        rise;

  assign rise = din & ~din_d_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || rise)
    begin
      hi_cnt_reg  <= 16'h0000;
      per_cnt_reg <= 16'h0000;
    end
    else if (tick)
    begin
      if (per_cnt_reg != 16'hFFFF)
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      if (din && hi_cnt_reg != 16'hFFFF)
        hi_cnt_reg <= hi_cnt_reg + 16'h0001;
    end
  end

  // frame state
  logic [4:0]  sym_cnt_reg;
  logic        in_frame_reg;
  logic [18:0] shift_reg;
  logic        skip_reg;
  logic        close_stb;
  logic        sym_evt;
  swrx_sym_e   sym;

  // closing delimiter ends once low time equals high time,
  // since an idle line after it would never give an edge
  assign close_stb = in_frame_reg && sym_cnt_reg == FRAME_SYMS &&
                     !skip_reg && !din && tick && hi_cnt_reg != 16'h0 &&
                     (per_cnt_reg - hi_cnt_reg) == hi_cnt_reg;
  assign sym_evt   = (rise & ~skip_reg) | close_stb;
  assign sym = swrx_classify(hi_cnt_reg, close_stb ?
               {hi_cnt_reg[14:0], 1'b0} : per_cnt_reg);

  logic frame_done;
  logic frame_err;
  logic par_ok;
  logic frame_ok;
  logic par_bad;

  always_comb
  begin
    frame_done = 1'b0;
    frame_err  = 1'b0;
    if (sym_evt)
    begin
      case (sym)
        SYM_BAD:   frame_err = 1'b1;
        SYM_DELIM:
        begin
          frame_done = in_frame_reg && sym_cnt_reg == FRAME_SYMS;
          frame_err  = in_frame_reg && sym_cnt_reg != 5'h0 &&
                       sym_cnt_reg != FRAME_SYMS;
        end
        default:   frame_err = in_frame_reg &&
                               sym_cnt_reg == FRAME_SYMS;
      endcase
    end
  end

  // parity: tag plus upper byte, then lower byte alone
  assign par_ok = shift_reg[1] == swrx_even(shift_reg[18:10]) &&
                  shift_reg[0] == swrx_even({1'b0, shift_reg[9:2]});
  assign frame_ok = frame_done & par_ok;
  assign par_bad  = frame_done & ~par_ok;

  // the gap after a closed frame or at power-up is not a symbol
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sym_cnt_reg  <= 5'h0;
      in_frame_reg <= 1'b0;
      shift_reg    <= 19'h0;
      skip_reg     <= 1'b1;
    end
    else
    begin
      if (close_stb)
        skip_reg <= 1'b1;
      else if (rise)
        skip_reg <= 1'b0;
      if (sym_evt)
      begin
        case (sym)
          SYM_BAD:   in_frame_reg <= 1'b0;
          SYM_DELIM:
          begin
            in_frame_reg <= 1'b1;
            sym_cnt_reg  <= 5'h0;
          end
          default:
          begin
            if (in_frame_reg && sym_cnt_reg == FRAME_SYMS)
              in_frame_reg <= 1'b0;
            else if (in_frame_reg)
            begin
              shift_reg   <= {shift_reg[17:0], sym == SYM_ONE};
              sym_cnt_reg <= sym_cnt_reg + 5'h1;
            end
          end
        endcase
      end
    end
  end

  // software registers
  logic [4:0]   ctrl_reg;
  logic [15:0]  alarm_lo_reg;
  logic [15:0]  alarm_hi_reg;
  logic [4:0]   int_stat_reg;
  logic [4:0]   int_mask_reg;
  logic [15:0]  code_reg;
  logic         code_valid_reg;
  swrx_faults_s mask;
  logic         wr_go;
  logic [31:0]  wmask;

  assign mask  = swrx_faults_s'(ctrl_reg[3:0]);
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (s_axi_wdata & wmask);
  endfunction : merge

  // code and config from frames; a link write lands after axi
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg       <= CTRL_RST;
      alarm_lo_reg   <= ALARM_LO_RST;
      alarm_hi_reg   <= ALARM_HI_RST;
      int_mask_reg   <= 5'h00;
      code_reg       <= 16'h0000;
      code_valid_reg <= 1'b0;
    end
    else
    begin
      if (wr_go)
      begin
        case (s_axi_awaddr)
          REG_CTRL:     ctrl_reg     <= 5'(merge(32'(ctrl_reg)));
          REG_ALARM_LO: alarm_lo_reg <= 16'(merge(32'(alarm_lo_reg)));
          REG_ALARM_HI: alarm_hi_reg <= 16'(merge(32'(alarm_hi_reg)));
          REG_INT_MASK: int_mask_reg <= 5'(merge(32'(int_mask_reg)));
          default:      ;
        endcase
      end
      if (frame_ok && !shift_reg[18])
      begin
        code_reg       <= shift_reg[17:2];
        code_valid_reg <= 1'b1;
      end
      else if (frame_ok)
      begin
        case (shift_reg[17:10])
          LINK_MASK:     ctrl_reg <= shift_reg[6:2];
          LINK_ALARM_LO: alarm_lo_reg <= {shift_reg[9:2], 8'h00};
          LINK_ALARM_HI: alarm_hi_reg <= {shift_reg[9:2], 8'h00};
          default:       ;
        endcase
      end
    end
  end

  // fault timers share the tick; timeout compares in ticks
  logic [TO_W-1:0] act_cnt_reg;
  logic [TO_W-1:0] loop_cnt_reg;
  swrx_faults_s    flt_reg;
  logic            to_act;
  logic            to_loop;
  logic            loop_set;
  logic            chan_set;

  assign to_act  = tick && act_cnt_reg == TO_W'(TIMEOUT_TICKS_P - 1);
  assign to_loop = tick && loop_cnt_reg == TO_W'(TIMEOUT_TICKS_P - 1);
  assign loop_set = loop_in & ~flt_reg.loop;
  assign chan_set = to_act & ~flt_reg.chan;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || (sym_evt && sym != SYM_BAD))
      act_cnt_reg <= '0;
    else if (tick && !to_act)
      act_cnt_reg <= act_cnt_reg + TO_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !flt_reg.loop || to_loop)
      loop_cnt_reg <= '0;
    else if (tick)
      loop_cnt_reg <= loop_cnt_reg + TO_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flt_reg <= '0;
    else
    begin
      if (loop_set)
        flt_reg.loop <= 1'b1;
      else if (to_loop)
        flt_reg.loop <= 1'b0;
      if (to_act)
        flt_reg.chan <= 1'b1;
      else if (sym_evt && sym != SYM_BAD)
        flt_reg.chan <= 1'b0;
      if (par_bad)
        flt_reg.parity <= 1'b1;
      else if (frame_ok)
        flt_reg.parity <= 1'b0;
      if (frame_err)
        flt_reg.frame <= 1'b1;
      else if (frame_ok)
        flt_reg.frame <= 1'b0;
    end
  end

  // alarm selection and output code
  swrx_faults_s flt_en;
  logic         any_flt;
  logic [15:0]  alarm;
  logic [15:0]  out_reg;
  logic         flag_reg;

  assign flt_en  = flt_reg & mask;
  assign any_flt = |flt_en;
  assign alarm   = flt_en.loop ? alarm_lo_reg :
                   band ? alarm_hi_reg : alarm_lo_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_reg  <= ALARM_LO_RST;
      flag_reg <= 1'b0;
    end
    else
    begin
      // stored code is never touched by faults, so it comes back
      out_reg  <= (any_flt || !code_valid_reg) ? alarm
                                               : code_reg;
      flag_reg <= any_flt;
    end
  end

  assign conversion_out = out_reg;
  assign fault_flag_n   = ~flag_reg;
  assign fault_flag_oe  = flag_reg;

  // acknowledge slot, timed from the closing delimiter period
  swrx_ack_e   ack_st_reg;
  logic [15:0] ack_per_reg;
  logic [18:0] ack_cnt_reg;
  logic        ack_low_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_st_reg  <= ACK_IDLE;
      ack_per_reg <= 16'h0000;
      ack_cnt_reg <= 19'h0;
      ack_low_reg <= 1'b0;
    end
    else
    begin
      if (tick)
        ack_cnt_reg <= ack_cnt_reg + 19'h1;
      case (ack_st_reg)
        ACK_IDLE:
        begin
          if (frame_ok && ctrl_reg[4])
          begin
            ack_st_reg  <= ACK_WAIT;
            ack_per_reg <= {hi_cnt_reg[14:0], 1'b0};
            ack_cnt_reg <= 19'h0;
          end
        end
        ACK_WAIT:
        begin
          if (ack_cnt_reg >= {5'h0, ack_per_reg[15:2]})
          begin
            ack_st_reg  <= ACK_LOW;
            ack_low_reg <= 1'b1;
          end
        end
        ACK_LOW:
        begin
          if (ack_cnt_reg >= ((19'(ACK_REL_Q) * 19'(ack_per_reg)) >> 2))
          begin
            ack_st_reg  <= ACK_IDLE;
            ack_low_reg <= 1'b0;
          end
        end
        default: ack_st_reg <= ACK_IDLE;
      endcase
    end
  end

  assign ack_pulldown_n  = ~ack_low_reg;
  assign ack_pulldown_oe = ack_low_reg;

  // sticky events; a new event wins over a one written back
  logic [4:0] events;

  assign events = {frame_ok, loop_set, chan_set, par_bad, frame_err};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_stat_reg <= 5'h00;
    else if (wr_go && s_axi_awaddr == REG_INT_STAT)
      int_stat_reg <= (int_stat_reg & ~(s_axi_wdata[4:0] & wmask[4:0]))
                      | events;
    else
      int_stat_reg <= int_stat_reg | events;
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  // axi4-lite answers: both write channels taken together
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = ~s_axi_rvalid;

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= REG_INT_MASK;
  endfunction : mapped

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL:     s_axi_rdata <= {27'h0, ctrl_reg};
        REG_STATUS:   s_axi_rdata <= {25'h0, band, flag_reg,
                                      code_valid_reg, flt_reg};
        REG_CODE:     s_axi_rdata <= {16'h0, code_reg};
        REG_OUTPUT:   s_axi_rdata <= {16'h0, out_reg};
        REG_ALARM_LO: s_axi_rdata <= {16'h0, alarm_lo_reg};
        REG_ALARM_HI: s_axi_rdata <= {16'h0, alarm_hi_reg};
        REG_INT_STAT: s_axi_rdata <= {27'h0, int_stat_reg};
        REG_INT_MASK: s_axi_rdata <= {27'h0, int_mask_reg};
        default:      s_axi_rdata <= 32'h0;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : swrx_top

`default_nettype wire

// *** hw/swrx_pkg.sv ***
package swrx_pkg;

  // clock and internal timer
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 250;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS    = 100;
  localparam int TIMEOUT_TICKS = TIMEOUT_MS * 1000000 / TICK_NS;
  localparam int TO_W          = 24;

  // symbol rate window, in timer ticks (shortest rounds down)
  localparam int SYM_RATE_MAX_HZ = 19200;
  localparam int SYM_RATE_MIN_HZ = 300;
  localparam logic [15:0] PER_MIN_TICKS =
    16'(1000000000 / (SYM_RATE_MAX_HZ * TICK_NS));
  localparam logic [15:0] PER_MAX_TICKS =
    16'(1000000000 / (SYM_RATE_MIN_HZ * TICK_NS));

  // duty windows in sixteenths of the symbol period
  localparam logic [4:0] DUTY_DEN = 5'h10;
  localparam logic [4:0] DELIM_LO = 5'h07;
  localparam logic [4:0] DELIM_HI = 5'h09;
  localparam logic [4:0] ZERO_LO  = 5'h03;
  localparam logic [4:0] ZERO_HI  = 5'h05;
  localparam logic [4:0] ONE_LO   = 5'h0B;
  localparam logic [4:0] ONE_HI   = 5'h0D;

  // frame: tag, 16 payload, two parity symbols
  localparam logic [4:0] FRAME_SYMS = 5'h13;
  localparam logic [2:0] ACK_REL_Q  = 3'h7;  // release, quarters

  // axi4-lite register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CODE     = 8'h08;
  localparam logic [7:0] REG_OUTPUT   = 8'h0C;
  localparam logic [7:0] REG_ALARM_LO = 8'h10;
  localparam logic [7:0] REG_ALARM_HI = 8'h14;
  localparam logic [7:0] REG_INT_STAT = 8'h18;
  localparam logic [7:0] REG_INT_MASK = 8'h1C;

  // configuration addresses carried in link frames
  localparam logic [7:0] LINK_MASK     = 8'h01;
  localparam logic [7:0] LINK_ALARM_LO = 8'h02;
  localparam logic [7:0] LINK_ALARM_HI = 8'h03;

  // reset values
  localparam logic [4:0]  CTRL_RST     = 5'h1F;
  localparam logic [15:0] ALARM_LO_RST = 16'h0C00;
  localparam logic [15:0] ALARM_HI_RST = 16'hF000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SYM_ZERO  = 2'b00,
    SYM_ONE   = 2'b01,
    SYM_DELIM = 2'b10,
    SYM_BAD   = 2'b11
  } swrx_sym_e;

  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_LOW  = 2'b10
  } swrx_ack_e;

  // fault classes, also the layout of mask and interrupt bits
  typedef struct packed {
    logic loop;
    logic chan;
    logic parity;
    logic frame;
  } swrx_faults_s;

  // sort a finished symbol by its high time against its period
  function automatic swrx_sym_e swrx_classify(input logic [15:0] h,
                                             input logic [15:0] p);
    logic [23:0] h16;
    logic [23:0] p24;  // widened so slow periods do not wrap
    h16 = {4'h0, h, 4'h0};
    p24 = 24'(p);
    if (p < PER_MIN_TICKS || p > PER_MAX_TICKS)
      return SYM_BAD;
    if (h16 >= DELIM_LO * p24 && h16 <= DELIM_HI * p24)
      return SYM_DELIM;
    if (h16 >= ZERO_LO * p24 && h16 <= ZERO_HI * p24)
      return SYM_ZERO;
    if (h16 >= ONE_LO * p24 && h16 <= ONE_HI * p24)
      return SYM_ONE;
    return SYM_BAD;
  endfunction : swrx_classify

  // one when the slice holds an even count of ones
  function automatic logic swrx_even(input logic [8:0] x);
    return ~^x;
  endfunction : swrx_even

endpackage : swrx_pkg

// *** bench/swrx_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the top ports only; link bounds are in clock cycles
module swrx_top_chk
  import swrx_pkg::*;
#(
  parameter int TIMEOUT_TICKS_P = TIMEOUT_TICKS
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link and fault pins
  input wire logic        ack_pulldown_n,
  input wire logic        ack_pulldown_oe,
  input wire logic        loop_fail,
  input wire logic        fault_flag_n,
  input wire logic        fault_flag_oe
);
  // ack low span: one to 30/16 periods over the whole rate range
  localparam int ACK_MIN = int'(PER_MIN_TICKS) * TICK_CYC;
  localparam int ACK_MAX = int'(PER_MAX_TICKS) * TICK_CYC * 30 / 16;
  int ack_cnt;

  // length of the current acknowledge, in cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ack_pulldown_n)
      ack_cnt <= 0;
    else
      ack_cnt <= ack_cnt + 1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flag_enable_a: assert property (fault_flag_oe == !fault_flag_n)
    else $error("fault flag enable disagrees with flag");
  ack_enable_a: assert property (ack_pulldown_oe == !ack_pulldown_n)
    else $error("ack enable disagrees with ack level");
  aw_pair_a: assert property (s_axi_awready |-> s_axi_wready &&
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
    else $error("write address taken without its data");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  loop_flag_a: assert property ($rose(loop_fail) ##1 loop_fail [*7]
      |-> !fault_flag_n)
    else $error("loop failure not flagged");
  ack_width_a: assert property ($rose(ack_pulldown_n) |->
      ack_cnt >= ACK_MIN && ack_cnt <= ACK_MAX)
    else $error("acknowledge width out of range");
endmodule : swrx_top_chk
`default_nettype wire

// *** bench/swrx_link_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// link master; symbols are whole periods, line low when idle
module swrx_link_master
  import swrx_pkg::*;
#(
  parameter int PER_TICKS = 224
) (
  input  wire logic aclk,
  output logic      swif_din,
  input  wire logic ack_pulldown_n
);
  int ack_fall;
  int ack_rise;

  // idle low from time zero
  initial swif_din = 1'b0;

  // high for hi sixteenths, low for the rest of the period
  task automatic sym(input int hi);
    swif_din <= 1'b1;
    repeat (hi * PER_TICKS * TICK_CYC / 16) @(posedge aclk);
    swif_din <= 1'b0;
    repeat ((16 - hi) * PER_TICKS * TICK_CYC / 16) @(posedge aclk);
  endtask : sym

  // flip inverts the first parity symbol to force a check failure
  task automatic frame(input logic tag, input logic [15:0] d,
                       input logic flip);
    logic p1;
    logic p0;
    int   i;
    p1 = ~^{tag, d[15:8]};
    p0 = ~^d[7:0];
    sym(8);
    sym(tag ? 12 : 4);
    for (i = 15; i >= 0; i--)
      sym(d[i] ? 12 : 4);
    sym((p1 ^ flip) ? 12 : 4);
    sym(p0 ? 12 : 4);
    sym(8);
    // listen over the two-period slot, cycles from its start
    ack_fall = -1;
    ack_rise = -1;
    for (i = 0; i < 2 * PER_TICKS * TICK_CYC && ack_rise < 0; i++)
    begin
      @(posedge aclk);
      if (ack_pulldown_n === 1'b0 && ack_fall < 0)
        ack_fall = i;
      if (ack_pulldown_n === 1'b1 && ack_fall >= 0)
        ack_rise = i;
    end
  endtask : frame
endmodule : swrx_link_master
`default_nettype wire

// *** bench/swrx_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module swrx_top_tb
  import swrx_pkg::*;
;
  // short timeout keeps the run near a million cycles
  localparam int TO_T = 1000;
  localparam int PC   = 224 * TICK_CYC;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        loop_fail = 1'b0;
  logic        alarm_band_select = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, swif_din, ack_pulldown_n, ack_pulldown_oe;
  logic        fault_flag_n, fault_flag_oe, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] conversion_out;
  logic [31:0] seed = 32'h18;
  logic [65:0] rq[$];
  logic [65:0] note;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #(CLK_PERIOD_NS / 2.0) aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  swrx_top #(.TIMEOUT_TICKS_P(TO_T)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .swif_din,
    .ack_pulldown_n, .ack_pulldown_oe, .loop_fail, .alarm_band_select,
    .fault_flag_n, .fault_flag_oe, .conversion_out, .irq);
  swrx_link_master #(.PER_TICKS(224)) lnk_u (.aclk, .swif_din,
    .ack_pulldown_n);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic hang(input string nm);
    mismatches++;
    $display("MISMATCH %s expected answer seen none", nm);
    end_sim();
  endtask : hang

  // ready is looked at mid-cycle, so it equals what the edge samples
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int i;
    i = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1 && ++i < 64);
    if (i >= 64) hang("awready");
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1 && ++i < 128);
    if (i >= 128) hang("bvalid");
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", r, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // expectation goes on the queue; the monitor compares on rvalid
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m, input logic [1:0] r);
    int i;
    i = 0;
    rq.push_back({m, e, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1 && ++i < 64);
    if (i >= 64) hang("arready");
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1 && ++i < 128);
    if (i >= 128) hang("rvalid");
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // read monitor: oldest note against each delivered word
  always @(posedge aclk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      note = rq.pop_front();
      chk("rdata", note[33:2] & note[65:34], s_axi_rdata & note[65:34]);
      chk("rresp", note[1:0], s_axi_rresp);
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] ah;
    logic [15:0] c;
    int          i;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("conv", ALARM_LO_RST, conversion_out);
    chk("flag", 1, fault_flag_n);
    axi_rd(REG_CTRL, CTRL_RST, 32'h1F, RESP_OKAY);
    axi_rd(REG_ALARM_LO, ALARM_LO_RST, 32'hFFFF, RESP_OKAY);
    axi_rd(REG_ALARM_HI, ALARM_HI_RST, 32'hFFFF, RESP_OKAY);
    axi_rd(REG_INT_MASK, 32'h0, 32'h1F, RESP_OKAY);
    axi_rd(8'h20, 32'h0, 32'h0, RESP_SLVERR);
    ah = 16'(rnd());
    axi_wr(REG_ALARM_HI, {16'h0, ah}, RESP_OKAY);
    axi_wr(8'h16, 32'hFFFFFFFF, RESP_SLVERR);
    axi_wr(REG_CODE, 32'h1234, RESP_OKAY);
    axi_rd(REG_ALARM_HI, {16'h0, ah}, 32'hFFFF, RESP_OKAY);
    axi_wr(REG_INT_MASK, 32'h4, RESP_OKAY);
    alarm_band_select <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("conv", ah, conversion_out);
    i = 0;
    do @(posedge aclk);
    while (fault_flag_n !== 1'b0 && ++i < 2 * TO_T * TICK_CYC);
    if (i >= 2 * TO_T * TICK_CYC) hang("chan");
    chk("chan", 1, cyc >= TO_T * TICK_CYC * 9 / 10 &&
        cyc <= TO_T * TICK_CYC * 11 / 10);
    repeat (4) @(posedge aclk);
    chk("conv", ah, conversion_out);
    chk("irq", 1, irq);
    axi_rd(REG_STATUS, 32'h44, 32'h44, RESP_OKAY);
    axi_wr(REG_INT_STAT, 32'h4, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq", 0, irq);
    c = 16'(rnd());
    lnk_u.frame(1'b0, c, 1'b0);
    chk("conv", c, conversion_out);
    chk("flag", 1, fault_flag_n);
    chk("ackon", 1, lnk_u.ack_fall >= PC / 16 &&
        lnk_u.ack_fall <= PC / 2);
    chk("ackoff", 1, lnk_u.ack_rise >= PC * 3 / 2 &&
        lnk_u.ack_rise <= PC * 31 / 16);
    chk("irq", 0, irq);
    axi_rd(REG_CODE, {16'h0, c}, 32'hFFFF, RESP_OKAY);
    axi_rd(REG_INT_STAT, 32'h10, 32'h10, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1B, RESP_OKAY);
    loop_fail <= 1'b1;
    repeat (20) @(posedge aclk);
    chk("flag", 0, fault_flag_n);
    chk("conv", ALARM_LO_RST, conversion_out);
    loop_fail <= 1'b0;
    repeat (TO_T * TICK_CYC / 2) @(posedge aclk);
    chk("conv", ALARM_LO_RST, conversion_out);
    repeat (TO_T * TICK_CYC / 2 + 200) @(posedge aclk);
    chk("conv", c, conversion_out);
    chk("flag", 1, fault_flag_n);
    lnk_u.frame(1'b0, 16'(rnd()), 1'b1);
    chk("flag", 0, fault_flag_n);
    chk("conv", ah, conversion_out);
    chk("noack", 32'hFFFFFFFF, 32'(lnk_u.ack_fall));
    axi_rd(REG_CODE, {16'h0, c}, 32'hFFFF, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h19, RESP_OKAY);
    repeat (10) @(posedge aclk);
    chk("flag", 1, fault_flag_n);
    chk("conv", c, conversion_out);
    lnk_u.sym(8);
    lnk_u.sym(6);
    lnk_u.sym(8);
    repeat (10) @(posedge aclk);
    chk("flag", 0, fault_flag_n);
    chk("conv", ah, conversion_out);
    alarm_band_select <= 1'b0;
    repeat (10) @(posedge aclk);
    chk("conv", ALARM_LO_RST, conversion_out);
    lnk_u.frame(1'b1, {LINK_ALARM_LO, ah[7:0]}, 1'b0);
    axi_rd(REG_ALARM_LO, {ah[7:0], 8'h00}, 32'hFFFF, RESP_OKAY);
    axi_rd(REG_OUTPUT, {16'h0, c}, 32'hFFFF, RESP_OKAY);
    end_sim();
  end

  // cuts a hang short
  initial
  begin
    repeat (1100000) @(posedge aclk);
    hang("run");
  end
endmodule : swrx_top_tb

bind swrx_top swrx_top_chk #(.TIMEOUT_TICKS_P(TIMEOUT_TICKS_P)) chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .ack_pulldown_n, .ack_pulldown_oe, .loop_fail,
  .fault_flag_n, .fault_flag_oe);
`default_nettype wire
